// [design/uart_mode_pkg.sv]
// constants and types for the serial mode, error status and baud control
// assumes an 8-bit cpu data bus with 16-bit byte addresses
package uart_mode_pkg;

  // register byte addresses on the cpu memory bus
  localparam logic [15:0] ADDR_MODE   = 16'hffa0;
  localparam logic [15:0] ADDR_STATUS = 16'hffa1;
  localparam logic [15:0] ADDR_BAUD   = 16'hffa2;
  localparam logic [15:0] ADDR_RXBUF  = 16'hffa3;

  // reset values
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] BAUD_RESET   = 8'h00;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [7:0] RXBUF_RESET  = 8'h00;

  // writable bits: mode bit 0 and baud bit 7 are fixed at zero
  localparam logic [7:0] MODE_WMASK = 8'hfe;
  localparam logic [7:0] BAUD_WMASK = 8'h7f;

  // mode register fields
  localparam int MODE_TXE_BIT  = 7;
  localparam int MODE_RXE_BIT  = 6;
  localparam int MODE_PS_HI    = 5;
  localparam int MODE_PS_LO    = 4;
  localparam int MODE_CL_BIT   = 3;
  localparam int MODE_SL_BIT   = 2;
  localparam int MODE_ISRM_BIT = 1;

  // status register fields
  localparam int STAT_PE_BIT  = 2;
  localparam int STAT_FE_BIT  = 1;
  localparam int STAT_OVE_BIT = 0;

  // baud control fields
  localparam int BAUD_TPS_HI = 6;
  localparam int BAUD_TPS_LO = 4;
  localparam int BAUD_MDL_HI = 3;
  localparam int BAUD_MDL_LO = 0;

  // divider constants: period = (k + 16) << (n + 1), n = tps + 1
  localparam logic [4:0] BAUD_K_BASE  = 5'h10;
  localparam logic [3:0] BAUD_N_SHIFT = 4'h2;

  // parity encodings
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // data bit index of the last bit for 7 and 8 bit characters
  localparam logic [2:0] LAST_BIT_7 = 3'h6;
  localparam logic [2:0] LAST_BIT_8 = 3'h7;

  // transmit buffer depth
  localparam logic [1:0] TXBUF_DEPTH = 2'h2;

  typedef enum logic [2:0] {
    FR_IDLE,
    FR_START,
    FR_DATA,
    FR_PARITY,
    FR_STOP
  } frame_t;

endpackage : uart_mode_pkg

// [design/uart_mode_control_status.sv]
// serial interface: mode control, baud divider, tx/rx engines, error status
// assumes a cpu bus with one-cycle read/write strobes on ref_clk and an
// asynchronous serial input pin that is synchronised here

// Function
// - both enables zero: no transfer, both pins stay port pins
// - tx and rx enables act independently, each claims its own pin
// - full duplex: start bit then one character, both directions at once
// - parity field: none, zero bit unchecked, odd, even
// - character length bit: 0 seven data bits, 1 eight data bits
// - stop length bit: 0 one stop bit, 1 two stop bits on transmit
// - receiver checks only one stop bit regardless of stop length
// - suppress bit withholds receive completion interrupt on erroneous frames
// - status bit 2 set when received parity mismatches the scheme
// - status bit 1 set when the stop bit is not seen
// - status bit 0 set when a character completes before buffer read
// - overrun repeats on every character until the buffer is read
// - mode register takes bit and byte writes, resets zero, bit0 zero
// - status register read only, byte read, resets zero, top five zero
// - bit rate is clock over two to n+1 over k+16
module uart_mode_control_status (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  // cpu register bus
  input  wire logic [15:0] busAddr,
  input  wire logic        busWrEn,
  input  wire logic [7:0]  busWrData,
  input  wire logic        busBitWrEn,
  input  wire logic [2:0]  busBitSel,
  input  wire logic        busBitVal,
  input  wire logic        busRdEn,
  output logic      [7:0]  busRdData,
  // transmit character stream
  input  wire logic [7:0]  txData,
  input  wire logic        txValid,
  output logic             txReady,
  // serial pins
  input  wire logic        serialInPin,
  output logic             serialOutPin,
  output logic             txPinSerial,
  output logic             rxPinSerial,
  // receive completion event
  output logic             rxDoneIrq
);

  typedef struct packed {
    logic [7:0]          mode;
    logic [7:0]          baud;
    logic [2:0]          status;
    logic [7:0]          rxBuf;
    logic                rxFull;
    logic [7:0]          rdData;
    logic                irq;
    logic                txSer;
    logic                rxSer;
    logic                serOut;
    logic [1:0][7:0]     fifo;
    logic                wrIdx;
    logic                rdIdx;
    logic [1:0]          fifoCnt;
    logic                ready;
    uart_mode_pkg::frame_t txSt;
    logic [13:0]         txCnt;
    logic [2:0]          txBit;
    logic                txStop2;
    logic                txPar;
    logic [7:0]          txShift;
    uart_mode_pkg::frame_t rxSt;
    logic [13:0]         rxCnt;
    logic [2:0]          rxBit;
    logic                rxPar;
    logic [7:0]          rxShift;
    logic                inS1;
    logic                inS2;
    logic                inS3;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // bit period in ref_clk cycles from the baud control value
  function automatic logic [13:0] bitPeriod(input logic [7:0] b);
    logic [4:0] k;
    logic [3:0] sh;
    k  = {1'b0, b[uart_mode_pkg::BAUD_MDL_HI:uart_mode_pkg::BAUD_MDL_LO]}
         + uart_mode_pkg::BAUD_K_BASE;
    sh = {1'b0, b[uart_mode_pkg::BAUD_TPS_HI:uart_mode_pkg::BAUD_TPS_LO]}
         + uart_mode_pkg::BAUD_N_SHIFT;
    return 14'(k) << sh;
  endfunction : bitPeriod

  // parity bit for a character under the selected scheme
  function automatic logic parityBit(input logic [7:0] d,
                                     input logic [1:0] ps);
    logic p;
    p = 1'b0;
    if (ps == uart_mode_pkg::PAR_ODD) p = ~^d;
    else if (ps == uart_mode_pkg::PAR_EVEN) p = ^d;
    return p;
  endfunction : parityBit

  // keep seven bits when the short character length is selected
  function automatic logic [7:0] maskChar(input logic [7:0] d,
                                          input logic       cl);
    return cl ? d : {1'b0, d[6:0]};
  endfunction : maskChar

  // decoded controls and per-cycle helpers
  logic        txEnable;
  logic        rxEnable;
  logic [1:0]  parSel;
  logic        charLen;
  logic        stopLen;
  logic        errSuppress;
  logic [13:0] period;
  logic [2:0]  lastBit;
  logic        rdBuf;
  logic        pushTx;
  logic        popTx;
  logic        rxFinish;
  logic [7:0]  rxChar;
  logic        rxPe;
  logic        rxFe;
  logic        rxOve;
  logic        rxErr;

  always_comb begin
    txEnable    = s_reg.mode[uart_mode_pkg::MODE_TXE_BIT];
    rxEnable    = s_reg.mode[uart_mode_pkg::MODE_RXE_BIT];
    parSel      = s_reg.mode[uart_mode_pkg::MODE_PS_HI:
                             uart_mode_pkg::MODE_PS_LO];
    charLen     = s_reg.mode[uart_mode_pkg::MODE_CL_BIT];
    stopLen     = s_reg.mode[uart_mode_pkg::MODE_SL_BIT];
    errSuppress = s_reg.mode[uart_mode_pkg::MODE_ISRM_BIT];
    period      = bitPeriod(s_reg.baud);
    lastBit     = charLen ? uart_mode_pkg::LAST_BIT_8
                          : uart_mode_pkg::LAST_BIT_7;
    rdBuf       = busRdEn && (busAddr == uart_mode_pkg::ADDR_RXBUF);
    pushTx      = txValid && s_reg.ready;
    popTx       = txEnable && (s_reg.txSt == uart_mode_pkg::FR_IDLE)
                  && (s_reg.fifoCnt != 2'h0);
    rxFinish    = rxEnable && (s_reg.rxSt == uart_mode_pkg::FR_STOP)
                  && (s_reg.rxCnt == 14'h0);
    rxChar      = charLen ? s_reg.rxShift : {1'b0, s_reg.rxShift[7:1]};
    rxPe        = ((parSel == uart_mode_pkg::PAR_ODD)
                   || (parSel == uart_mode_pkg::PAR_EVEN))
                  && (s_reg.rxPar != parityBit(rxChar, parSel));
    rxFe        = !s_reg.inS2;
    rxOve       = s_reg.rxFull && !rdBuf;
    rxErr       = rxPe || rxFe || rxOve;
  end

  // next-state logic for registers, buffer and both frame engines
  always_comb begin
    s_next     = s_reg;
    s_next.irq = 1'b0;
    // serial input synchroniser and edge history
    s_next.inS1 = serialInPin;
    s_next.inS2 = s_reg.inS1;
    s_next.inS3 = s_reg.inS2;

    // byte writes; bit writes reach the mode register only
    if (busWrEn) begin
      if (busAddr == uart_mode_pkg::ADDR_MODE)
        s_next.mode = busWrData & uart_mode_pkg::MODE_WMASK;
      else if (busAddr == uart_mode_pkg::ADDR_BAUD)
        s_next.baud = busWrData & uart_mode_pkg::BAUD_WMASK;
    end else if (busBitWrEn && (busAddr == uart_mode_pkg::ADDR_MODE)) begin
      s_next.mode[busBitSel] = busBitVal;
      s_next.mode[0]         = 1'b0;
    end

    // read answer registered one cycle later, unmapped reads zero
    if (busRdEn) begin
      unique case (busAddr)
        uart_mode_pkg::ADDR_MODE:   s_next.rdData = s_reg.mode;
        uart_mode_pkg::ADDR_STATUS: s_next.rdData = {5'h00, s_reg.status};
        uart_mode_pkg::ADDR_BAUD:   s_next.rdData = s_reg.baud;
        uart_mode_pkg::ADDR_RXBUF:  s_next.rdData = s_reg.rxBuf;
        default:                    s_next.rdData = 8'h00;
      endcase
      if (rdBuf) s_next.rxFull = 1'b0;
    end

    // pin function select per direction
    s_next.txSer = txEnable;
    s_next.rxSer = rxEnable;

    // two-entry transmit buffer
    if (pushTx) begin
      s_next.fifo[s_reg.wrIdx] = txData;
      s_next.wrIdx             = !s_reg.wrIdx;
    end
    if (popTx) s_next.rdIdx = !s_reg.rdIdx;
    s_next.fifoCnt = s_reg.fifoCnt + {1'b0, pushTx} - {1'b0, popTx};
    s_next.ready   = s_next.fifoCnt < uart_mode_pkg::TXBUF_DEPTH;

    // transmit engine
    if (!txEnable) begin
      s_next.txSt   = uart_mode_pkg::FR_IDLE;
      s_next.serOut = 1'b1;
    end else if (s_reg.txSt == uart_mode_pkg::FR_IDLE) begin
      s_next.serOut = 1'b1;
      if (popTx) begin
        s_next.txShift = maskChar(s_reg.fifo[s_reg.rdIdx], charLen);
        s_next.txPar   = parityBit(s_next.txShift, parSel);
        s_next.serOut  = 1'b0;
        s_next.txCnt   = period - 14'h1;
        s_next.txSt    = uart_mode_pkg::FR_START;
      end
    end else if (s_reg.txCnt != 14'h0) begin
      s_next.txCnt = s_reg.txCnt - 14'h1;
    end else begin
      s_next.txCnt = period - 14'h1;
      unique case (s_reg.txSt)
        uart_mode_pkg::FR_START: begin
          s_next.txSt   = uart_mode_pkg::FR_DATA;
          s_next.txBit  = 3'h0;
          s_next.serOut = s_reg.txShift[0];
        end
        uart_mode_pkg::FR_DATA: begin
          if (s_reg.txBit == lastBit) begin
            if (parSel != uart_mode_pkg::PAR_NONE) begin
              s_next.txSt   = uart_mode_pkg::FR_PARITY;
              s_next.serOut = s_reg.txPar;
            end else begin
              s_next.txSt   = uart_mode_pkg::FR_STOP;
              s_next.serOut = 1'b1;
            end
            s_next.txStop2 = stopLen;
          end else begin
            s_next.txBit   = s_reg.txBit + 3'h1;
            s_next.txShift = s_reg.txShift >> 1;
            s_next.serOut  = s_reg.txShift[1];
          end
        end
        uart_mode_pkg::FR_PARITY: begin
          s_next.txSt   = uart_mode_pkg::FR_STOP;
          s_next.serOut = 1'b1;
        end
        uart_mode_pkg::FR_STOP: begin
          if (s_reg.txStop2) s_next.txStop2 = 1'b0;
          else s_next.txSt = uart_mode_pkg::FR_IDLE;
        end
        default: s_next.txSt = uart_mode_pkg::FR_IDLE;
      endcase
    end

    // receive engine, runs alongside the transmitter
    if (!rxEnable) begin
      s_next.rxSt = uart_mode_pkg::FR_IDLE;
    end else if (s_reg.rxSt == uart_mode_pkg::FR_IDLE) begin
      if (s_reg.inS3 && !s_reg.inS2) begin
        s_next.rxSt  = uart_mode_pkg::FR_START;
        s_next.rxCnt = (period >> 1) - 14'h1;
      end
    end else if (s_reg.rxCnt != 14'h0) begin
      s_next.rxCnt = s_reg.rxCnt - 14'h1;
    end else begin
      s_next.rxCnt = period - 14'h1;
      unique case (s_reg.rxSt)
        uart_mode_pkg::FR_START: begin
          // a start bit that is high again at mid-bit was a glitch
          if (s_reg.inS2) s_next.rxSt = uart_mode_pkg::FR_IDLE;
          else s_next.rxSt = uart_mode_pkg::FR_DATA;
          s_next.rxBit = 3'h0;
        end
        uart_mode_pkg::FR_DATA: begin
          s_next.rxShift = {s_reg.inS2, s_reg.rxShift[7:1]};
          s_next.rxBit   = s_reg.rxBit + 3'h1;
          if (s_reg.rxBit == lastBit) begin
            if (parSel != uart_mode_pkg::PAR_NONE)
              s_next.rxSt = uart_mode_pkg::FR_PARITY;
            else
              s_next.rxSt = uart_mode_pkg::FR_STOP;
          end
        end
        uart_mode_pkg::FR_PARITY: begin
          s_next.rxPar = s_reg.inS2;
          s_next.rxSt  = uart_mode_pkg::FR_STOP;
        end
        uart_mode_pkg::FR_STOP: begin
          // one stop bit sampled, a second one is never waited for
          s_next.rxSt   = uart_mode_pkg::FR_IDLE;
          s_next.status = {rxPe, rxFe, rxOve};
          if (!rxOve) begin
            s_next.rxBuf  = rxChar;
            s_next.rxFull = 1'b1; // completion wins over a same-cycle read
          end
          s_next.irq = !(rxErr && errSuppress);
        end
        default: s_next.rxSt = uart_mode_pkg::FR_IDLE;
      endcase
    end
  end

  // state register with synchronous reset and clock enable
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_reg         <= '0;
      s_reg.mode    <= uart_mode_pkg::MODE_RESET;
      s_reg.baud    <= uart_mode_pkg::BAUD_RESET;
      s_reg.status  <= uart_mode_pkg::STATUS_RESET;
      s_reg.rxBuf   <= uart_mode_pkg::RXBUF_RESET;
      s_reg.serOut  <= 1'b1;
      s_reg.ready   <= 1'b1;
      s_reg.inS1    <= 1'b1;
      s_reg.inS2    <= 1'b1;
      s_reg.inS3    <= 1'b1;
      s_reg.txSt    <= uart_mode_pkg::FR_IDLE;
      s_reg.rxSt    <= uart_mode_pkg::FR_IDLE;
    end else if (clkEn) begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign busRdData    = s_reg.rdData;
  assign txReady      = s_reg.ready;
  assign serialOutPin = s_reg.serOut;
  assign txPinSerial  = s_reg.txSer;
  assign rxPinSerial  = s_reg.rxSer;
  assign rxDoneIrq    = s_reg.irq;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence seq_rx_end;
    clkEn && rxFinish;
  endsequence

  sequence seq_rx_end_err;
    clkEn && rxFinish && rxErr;
  endsequence

  a_stop_mode_pins: assert property (
    clkEn && !txEnable && !rxEnable |=> !txPinSerial && !rxPinSerial)
    else $error("stop mode left a pin in serial use");

  a_rx_pin_serial: assert property (
    clkEn && rxEnable && !txEnable |=> rxPinSerial && !txPinSerial)
    else $error("receive only mode pin select wrong");

  a_tx_idle_high: assert property (
    s_reg.txSt == uart_mode_pkg::FR_IDLE |-> serialOutPin)
    else $error("serial output low while transmitter idle");

  a_zero_par_clean: assert property (
    seq_rx_end ##0 (parSel == uart_mode_pkg::PAR_ZERO)
    |=> !s_reg.status[uart_mode_pkg::STAT_PE_BIT])
    else $error("parity error raised under zero parity");

  a_parity_flag_set: assert property (
    seq_rx_end ##0 rxPe |=> s_reg.status[uart_mode_pkg::STAT_PE_BIT])
    else $error("parity mismatch not flagged");

  a_frame_flag_set: assert property (
    seq_rx_end ##0 !s_reg.inS2
    |=> s_reg.status[uart_mode_pkg::STAT_FE_BIT])
    else $error("missing stop bit not flagged");

  a_rx_single_stop: assert property (
    seq_rx_end |=> s_reg.rxSt == uart_mode_pkg::FR_IDLE)
    else $error("receiver waited past one stop bit");

  a_overrun_flag: assert property (
    seq_rx_end ##0 (s_reg.rxFull && !rdBuf)
    |=> s_reg.status[uart_mode_pkg::STAT_OVE_BIT] && $stable(s_reg.rxBuf))
    else $error("overrun not flagged or buffer overwritten");

  a_irq_suppress: assert property (
    seq_rx_end_err ##0 errSuppress |=> !rxDoneIrq)
    else $error("interrupt issued for suppressed error");

  a_irq_on_error: assert property (
    seq_rx_end ##0 !errSuppress |=> rxDoneIrq)
    else $error("completion interrupt missing");

  a_mode_lsb_zero: assert property (
    s_reg.mode[0] == 1'b0)
    else $error("mode register bit 0 not zero");

  a_status_upper: assert property (
    clkEn && busRdEn && (busAddr == uart_mode_pkg::ADDR_STATUS)
    |=> busRdData[7:3] == 5'h00)
    else $error("status upper bits not zero");

endmodule : uart_mode_control_status

// [dv/uart_remote_model.sv]
// remote serial device: decodes frames on the output pin, sends on input
// assumes bitTime in ref_clk periods of 100 ns, set by the bench
module uart_remote_model (
  // serial line from the block
  input  wire logic serialOutPin,
  // serial line into the block
  output logic      serialInPin
);
  timeunit 1ns;
  timeprecision 1ns;

  int  bitTime = 64;
  int  nBits   = 8;
  bit  parOn   = 1'b0;
  int  gotQ[$];
  time startQ[$];

  // idle line sits high
  initial serialInPin = 1'b1;

  // frame decoder: start check at mid bit, lsb first, one stop sample
  always begin : decode
    int  v;
    time t0;
    @(negedge serialOutPin);
    t0 = $time;
    v = 0;
    #(bitTime * 50);
    if (serialOutPin !== 1'b0) v = 32'h400;
    for (int i = 0; i < nBits; i++) begin
      #(bitTime * 100);
      v[i] = serialOutPin;
    end
    if (parOn) begin
      #(bitTime * 100);
      v[8] = serialOutPin;
    end
    #(bitTime * 100);
    v[9] = serialOutPin;
    gotQ.push_back(v);
    startQ.push_back(t0);
  end

  // one frame with a single stop bit; runs while decode runs
  task automatic sendFrame(input logic [7:0] d, input bit hasPar,
                           input bit pv, input bit sv);
    // move line changes off the clock edge
    #7;
    serialInPin = 1'b0;
    #(bitTime * 100);
    for (int i = 0; i < nBits; i++) begin
      serialInPin = d[i];
      #(bitTime * 100);
    end
    if (hasPar) begin
      serialInPin = pv;
      #(bitTime * 100);
    end
    serialInPin = sv;
    #(bitTime * 100);
    serialInPin = 1'b1;
  endtask : sendFrame
endmodule : uart_remote_model

// [dv/uart_mode_control_status_tb.sv]
// self-checking bench for mode control, error status and serial paths
// assumes the remote model on the pins and a 10 MHz ref_clk
module uart_mode_control_status_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk = 0, reset_n, clkEn, busWrEn, busBitWrEn;
  logic        busBitVal, busRdEn, txValid, txReady, serialInPin;
  logic        serialOutPin, txPinSerial, rxPinSerial, rxDoneIrq;
  logic [15:0] busAddr;
  logic [2:0]  busBitSel;
  logic [7:0]  busWrData, busRdData, txData, r, d, m;
  int          error_cnt, checks_done, irqCnt, seed, p, e, n;
  logic [5:0]  tbl [6] = '{6'h08, 6'h12, 6'h2a, 6'h36, 6'h3d, 6'h24};
  int          expQ[$];

  uart_mode_control_status uart_mode_control_status_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
    .busAddr(busAddr), .busWrEn(busWrEn), .busWrData(busWrData),
    .busBitWrEn(busBitWrEn), .busBitSel(busBitSel),
    .busBitVal(busBitVal), .busRdEn(busRdEn), .busRdData(busRdData),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .serialInPin(serialInPin), .serialOutPin(serialOutPin),
    .txPinSerial(txPinSerial), .rxPinSerial(rxPinSerial),
    .rxDoneIrq(rxDoneIrq));

  uart_remote_model uart_remote_model_i (
    .serialOutPin(serialOutPin), .serialInPin(serialInPin));

  // clock and receive event counter
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (rxDoneIrq === 1'b1) irqCnt++;

  // watchdog against a hang, about two and a half times the expected run length
  initial begin
    #4000000;
    error_cnt++;
    results();
  end

  task results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wrByte(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    busAddr <= a;
    busWrData <= v;
    busWrEn <= 1'b1;
    @(posedge ref_clk);
    busWrEn <= 1'b0;
  endtask : wrByte

  task wrBit(input logic [2:0] s, input logic v);
    @(posedge ref_clk);
    busAddr <= uart_mode_pkg::ADDR_MODE;
    busBitSel <= s;
    busBitVal <= v;
    busBitWrEn <= 1'b1;
    @(posedge ref_clk);
    busBitWrEn <= 1'b0;
  endtask : wrBit

  task rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    busAddr <= a;
    busRdEn <= 1'b1;
    @(posedge ref_clk);
    busRdEn <= 1'b0;
    @(posedge ref_clk);
    #1 v = busRdData;
  endtask : rd

  // push one word and queue the frame the remote side should see
  task push(input logic [7:0] v, input int ps, input int cl);
    logic [7:0] dm;
    dm = cl ? v : {1'b0, v[6:0]};
    expQ.push_back(dm | (ps ? parBit(dm, ps) << 8 : 0) | 32'h200);
    @(posedge ref_clk);
    txData <= v;
    txValid <= 1'b1;
    // hold the word until an edge that sees the buffer ready
    do @(posedge ref_clk); while (txReady !== 1'b1);
    txValid <= 1'b0;
  endtask : push

  task waitGot(input int cnt);
    for (int k = 0; k < 9000; k++)
      if (uart_remote_model_i.gotQ.size() < cnt) @(posedge ref_clk);
    // a limit that runs out counts as a mismatch
    if (uart_remote_model_i.gotQ.size() < cnt) error_cnt++;
  endtask : waitGot

  function automatic int parBit(input logic [7:0] v, input int ps);
    return ps == 1 ? 0 : (ps == 2 ? int'(~^v) : int'(^v));
  endfunction : parBit

  // main sequence
  initial begin
    {reset_n, busWrEn, busBitWrEn, busBitVal, busRdEn, txValid} = '0;
    {busAddr, busBitSel, busWrData, txData} = '0;
    clkEn = 1'b1;
    seed = 32'he5df;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(uart_mode_pkg::ADDR_MODE, r); chk(r, 8'h00);
    rd(uart_mode_pkg::ADDR_STATUS, r); chk(r, 8'h00);
    rd(16'h1234, r); chk(r, 8'h00);
    chk({txPinSerial, rxPinSerial, serialOutPin}, 3'h1);
    wrByte(uart_mode_pkg::ADDR_MODE, 8'hff);
    rd(uart_mode_pkg::ADDR_MODE, r); chk(r, 8'hfe);
    wrBit(3'h0, 1'b1);
    wrBit(3'h7, 1'b0);
    rd(uart_mode_pkg::ADDR_MODE, r); chk(r, 8'h7e);
    wrByte(uart_mode_pkg::ADDR_STATUS, 8'hff);
    rd(uart_mode_pkg::ADDR_STATUS, r); chk(r, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wrByte(uart_mode_pkg::ADDR_MODE, 8'(i << 6));
      @(posedge ref_clk);
      #1 chk({txPinSerial, rxPinSerial}, i);
      chk(serialOutPin, 1'b1);
    end
    // a write while the clock enable is low must not land
    @(posedge ref_clk);
    clkEn <= 1'b0;
    wrByte(uart_mode_pkg::ADDR_MODE, 8'h00);
    clkEn <= 1'b1;
    rd(uart_mode_pkg::ADDR_MODE, r); chk(r, 8'hc0);
    $display("test registers done");
    // each parity mode, both lengths and stop counts, two baud settings
    for (int i = 0; i < 4; i++) begin
      m = 8'((i << 4) | ((i & 1) << 3) | ((i >> 1) << 2));
      r = (i == 3) ? 8'h11 : 8'h00;
      p = ((r & 15) + 16) << (((r >> 4) & 7) + 2);
      wrByte(uart_mode_pkg::ADDR_BAUD, r);
      wrByte(uart_mode_pkg::ADDR_MODE, m);
      uart_remote_model_i.bitTime = p;
      uart_remote_model_i.nBits = (i & 1) ? 8 : 7;
      uart_remote_model_i.parOn = (i != 0);
      push(8'($random(seed)), i, i & 1);
      push(8'($random(seed)), i, i & 1);
      @(posedge ref_clk);
      #1 chk(txReady, 1'b0);
      wrByte(uart_mode_pkg::ADDR_MODE, m | 8'h80);
      waitGot(2);
      repeat (2) chk(uart_remote_model_i.gotQ.pop_front(), expQ.pop_front());
      e = (2 + uart_remote_model_i.nBits + (i != 0) + (i >> 1)) * p * 100;
      n = uart_remote_model_i.startQ[1] - uart_remote_model_i.startQ[0];
      chk(n >= e && n <= e + 400, 1'b1);
      uart_remote_model_i.startQ.delete();
      #(p * 300);
      wrByte(uart_mode_pkg::ADDR_MODE, 8'h00);
    end
    wrByte(uart_mode_pkg::ADDR_BAUD, 8'h00);
    uart_remote_model_i.bitTime = 64;
    $display("test transmit done");
    // receive table: parity, length, suppress, bad parity, bad stop
    for (int i = 0; i < 6; i++) begin
      // parity to bits 5:4, length to bit 3, suppress to bit 1
      m = 8'h40 | {2'h0, tbl[i][5:3], 1'b0, tbl[i][2], 1'b0};
      wrByte(uart_mode_pkg::ADDR_MODE, m);
      uart_remote_model_i.nBits = tbl[i][3] ? 8 : 7;
      d = 8'($random(seed));
      d = tbl[i][3] ? d : {1'b0, d[6:0]};
      n = irqCnt;
      uart_remote_model_i.sendFrame(d, tbl[i][5:4] != 0,
        1'(parBit(d, tbl[i][5:4])) ^ tbl[i][1], ~tbl[i][0]);
      #6400;
      e = (tbl[i][5] & tbl[i][1]) << 2 | tbl[i][0] << 1;
      rd(uart_mode_pkg::ADDR_STATUS, r); chk(r, e);
      chk(irqCnt - n, (e != 0 && tbl[i][2]) ? 0 : 1);
      rd(uart_mode_pkg::ADDR_RXBUF, r); chk(r, d);
    end
    $display("test receive done");
    // overrun with back-to-back single stop frames, two stops configured
    wrByte(uart_mode_pkg::ADDR_MODE, 8'h4c);
    uart_remote_model_i.nBits = 8;
    uart_remote_model_i.sendFrame(8'h5a, 0, 0, 1);
    #6400;
    rd(uart_mode_pkg::ADDR_STATUS, r); chk(r, 8'h00);
    uart_remote_model_i.sendFrame(8'h3c, 0, 0, 1);
    uart_remote_model_i.sendFrame(8'h99, 0, 0, 1);
    #6400;
    rd(uart_mode_pkg::ADDR_STATUS, r); chk(r, 8'h01);
    rd(uart_mode_pkg::ADDR_RXBUF, r); chk(r, 8'h5a);
    uart_remote_model_i.sendFrame(8'ha5, 0, 0, 1);
    #6400;
    rd(uart_mode_pkg::ADDR_STATUS, r); chk(r, 8'h00);
    rd(uart_mode_pkg::ADDR_RXBUF, r); chk(r, 8'ha5);
    $display("test overrun done");
    // both directions at once
    wrByte(uart_mode_pkg::ADDR_MODE, 8'hc8);
    uart_remote_model_i.parOn = 1'b0;
    d = 8'($random(seed));
    fork
      push(8'($random(seed)), 0, 1);
      uart_remote_model_i.sendFrame(d, 0, 0, 1);
    join
    waitGot(1);
    chk(uart_remote_model_i.gotQ.pop_front(), expQ.pop_front());
    #6400;
    rd(uart_mode_pkg::ADDR_RXBUF, r); chk(r, d);
    $display("test duplex done");
    results();
  end
endmodule : uart_mode_control_status_tb
